// ===== inc/rwa_pkg.sv
// Package for the register write alias decoder: register map, access
// kinds, alias space codes and the request and answer carriers.
// Assumes a single core clock shared with the host bus target logic.
package rwa_pkg;

	localparam int NREG = 47;
	localparam int SLOT_W = 6;
	localparam int ADDR_W = 20;

	typedef enum logic [1:0] {
		RWA_RW = 2'b00,
		RWA_WO = 2'b01,
		RWA_RO = 2'b10
	} rwa_access_e;

	typedef enum logic [2:0] {
		RWA_SP_REPLACE  = 3'b000,
		RWA_SP_ACCUM    = 3'b001,
		RWA_SP_RES2     = 3'b010,
		RWA_SP_RES3     = 3'b011,
		RWA_SP_REP_POS  = 3'b100,
		RWA_SP_ACC_POS  = 3'b101,
		RWA_SP_REP_NEG  = 3'b110,
		RWA_SP_ACC_NEG  = 3'b111
	} rwa_space_e;

	// Address fields inside the 1MB register space
	localparam int ALIAS_LSB = 11;
	localparam int ALIAS_MSB = 13;
	localparam int OFS_MSB = 10;
	localparam int ODD_BIT = 2;
	localparam int HALF_BIT = 19;

	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// Byte offsets within a 2KB alias, one per storage slot
	localparam logic [10:0] OFS_COPY_BUFFER_0 = 11'h000;
	localparam logic [10:0] OFS_PIXEL_MASK_ONE_SHOT = 11'h02c;
	localparam logic [10:0] OFS_DRAW_ADDRESS = 11'h03c;
	localparam logic [10:0] OFS_CONTINUE_TRIGGER = 11'h04c;
	localparam logic [10:0] OFS_PIXEL_MASK_PERSISTENT = 11'h05c;
	localparam logic [10:0] OFS_LOOP_DATA_VALUE = 11'h080;
	localparam logic [10:0] OFS_TRANSFER_BASE_ADDRESS = 11'h098;
	localparam logic [10:0] OFS_DITHER_ROW = 11'h0b0;
	localparam logic [10:0] OFS_DITHER_COLUMN = 11'h0b4;
	localparam logic [10:0] OFS_OCCLUSION_MAP_CURRENT = 11'h1f4;
	localparam logic [10:0] OFS_COMMAND_STATE = 11'h1f8;
	localparam logic [10:0] OFS_REFRESH_CURRENT_ADDRESS = 11'h1fc;
	localparam logic [10:0] OFS_LOOP_BEGIN = 11'h340;
	localparam logic [10:0] OFS_LOOP_END = 11'h350;

	localparam logic [10:0] REG_OFS [NREG] = '{
		OFS_COPY_BUFFER_0, 11'h004, 11'h008, 11'h00c,
		11'h010, 11'h014, 11'h018, 11'h01c,
		11'h020, 11'h024, OFS_PIXEL_MASK_ONE_SHOT, 11'h030,
		11'h034, 11'h038, OFS_DRAW_ADDRESS, 11'h040,
		11'h044, 11'h048, OFS_CONTINUE_TRIGGER, 11'h050,
		OFS_PIXEL_MASK_PERSISTENT, 11'h060, 11'h06c, 11'h070,
		11'h074, OFS_LOOP_DATA_VALUE, OFS_TRANSFER_BASE_ADDRESS, 11'h09c,
		11'h0ac, OFS_DITHER_ROW, OFS_DITHER_COLUMN, 11'h0bc,
		11'h0c4, 11'h0cc, 11'h0d0, 11'h0d4,
		11'h0e0, 11'h0e8, 11'h0ec, 11'h160,
		11'h164, OFS_OCCLUSION_MAP_CURRENT, OFS_COMMAND_STATE,
		OFS_REFRESH_CURRENT_ADDRESS,
		OFS_LOOP_BEGIN, OFS_LOOP_END, 11'h360
	};

	localparam rwa_access_e REG_ACC [NREG] = '{
		RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW,
		RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW,
		RWA_RW, RWA_RW, RWA_WO, RWA_RW, RWA_WO, RWA_RW, RWA_RW, RWA_RW,
		RWA_RW, RWA_RW, RWA_RW, RWA_WO, RWA_WO, RWA_RW, RWA_RW, RWA_RW,
		RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_RW, RWA_WO,
		RWA_WO, RWA_RO, RWA_RO, RWA_RO, RWA_WO, RWA_WO, RWA_WO
	};

	// Slot numbers used by the decoder itself
	localparam logic [SLOT_W-1:0] SLOT_DRAW_ADDRESS = 6'h0e;
	localparam logic [SLOT_W-1:0] SLOT_CONTINUE_TRIGGER = 6'h12;
	localparam logic [SLOT_W-1:0] SLOT_LOOP_DATA_VALUE = 6'h19;
	localparam logic [SLOT_W-1:0] SLOT_OCCLUSION_MAP_CURRENT = 6'h29;
	localparam logic [SLOT_W-1:0] SLOT_COMMAND_STATE = 6'h2a;
	localparam logic [SLOT_W-1:0] SLOT_REFRESH_CURRENT_ADDRESS = 6'h2b;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic              alt;
		logic [ADDR_W-1:0] addr;
		logic [3:0]        be;
		logic [31:0]       data;
	} rwa_req_s;

	typedef struct packed {
		logic [31:0] occlusion_map_current;
		logic [31:0] command_state;
		logic [31:0] refresh_current_address;
	} rwa_status_s;

	typedef struct packed {
		logic              pulse;
		logic [SLOT_W-1:0] slot;
		logic [31:0]       data;
	} rwa_update_s;

endpackage

// ===== core/rwa_decoder.sv
// Register write alias decoder: first-window register space and
// alternate control space writes, register storage and read back.
// Assumes the host target logic and the drawing engines share sys_clk.
`timescale 1ns/100ps

module rwa_decoder
	import rwa_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	input  wire logic                    clk_en,
	input  wire rwa_pkg::rwa_req_s       host_req,
	input  wire rwa_pkg::rwa_status_s    engine_status,
	output logic [31:0]                  rd_data,
	output logic                         rd_ack,
	output logic [rwa_pkg::NREG-1:0][31:0] reg_values,
	output rwa_pkg::rwa_update_s         reg_update,
	output logic                         loop_sign
);
	import rwa_pkg::*;

	typedef struct packed {
		logic [NREG-1:0][31:0] regs;
		logic                  sign;
		logic [31:0]           rdata;
		logic                  rack;
		rwa_update_s           upd;
	} rwa_state_s;

	rwa_state_s state_reg;
	rwa_state_s state_next;

	// Offset to storage slot; hit is low for reserved offsets
	function automatic logic [SLOT_W:0] slot_of(input logic [OFS_MSB:0] ofs);
		logic [SLOT_W:0] res;
		res = '0;
		for (int i = 0; i < NREG; i++)
		begin
			if (REG_OFS[i] == ofs)
			begin
				res = {1'b1, SLOT_W'(i)};
			end
		end
		return res;
	endfunction

	// Registers reachable through the accumulate and conditional aliases
	function automatic logic subset_reg(input logic [OFS_MSB:0] ofs);
		return (ofs == OFS_LOOP_DATA_VALUE) || (ofs == OFS_DITHER_ROW)
			|| (ofs == OFS_DITHER_COLUMN) || (ofs == OFS_TRANSFER_BASE_ADDRESS);
	endfunction

	logic [OFS_MSB:0] req_ofs;
	logic [SLOT_W:0]  req_hit;
	logic [SLOT_W-1:0] req_slot;
	rwa_space_e       req_space;
	logic             full_word;
	logic             do_write;
	logic             do_accum;
	logic             allowed;

	always_comb
	begin
		// Region and alias repeat: low offset bits pick the register
		// region decode
		req_ofs = {host_req.addr[OFS_MSB:2], 2'b00};
		req_hit = slot_of(req_ofs);
		req_slot = req_hit[SLOT_W-1:0];
		req_space = rwa_space_e'(host_req.addr[ALIAS_MSB:ALIAS_LSB]);
		full_word = (host_req.be == 4'hf);
		do_write = 1'b0;
		do_accum = 1'b0;
		allowed = 1'b0;

		state_next = state_reg;
		state_next.rack = 1'b0;
		state_next.upd.pulse = 1'b0;

		if (host_req.wr && host_req.alt)
		begin
			state_next.upd.pulse = 1'b1;
			state_next.upd.data = host_req.data;
			if (!host_req.addr[HALF_BIT] && !host_req.addr[ODD_BIT])
			begin
				state_next.regs[SLOT_DRAW_ADDRESS] = host_req.data;
				state_next.upd.slot = SLOT_DRAW_ADDRESS;
			end
			else
			begin
				state_next.regs[SLOT_CONTINUE_TRIGGER] = host_req.data;
				state_next.upd.slot = SLOT_CONTINUE_TRIGGER;
			end
		end
		else if (host_req.wr && full_word && req_hit[SLOT_W])
		begin
			case (req_space)
				RWA_SP_REPLACE:
				begin
					allowed = 1'b1;
				end
				RWA_SP_ACCUM:
				begin
					allowed = subset_reg(req_ofs);
					do_accum = 1'b1;
				end
				RWA_SP_REP_POS:
				begin
					allowed = subset_reg(req_ofs) && !state_reg.sign;
				end
				RWA_SP_ACC_POS:
				begin
					allowed = subset_reg(req_ofs) && !state_reg.sign;
					do_accum = 1'b1;
				end
				RWA_SP_REP_NEG:
				begin
					allowed = subset_reg(req_ofs) && state_reg.sign;
				end
				RWA_SP_ACC_NEG:
				begin
					allowed = subset_reg(req_ofs) && state_reg.sign;
					do_accum = 1'b1;
				end
				default:
				begin
					allowed = 1'b0;
				end
			endcase
			do_write = allowed && (REG_ACC[req_slot] != RWA_RO);
			if (do_write)
			begin
				if (do_accum)
				begin
					state_next.regs[req_slot] = state_reg.regs[req_slot] + host_req.data;
				end
				else
				begin
					state_next.regs[req_slot] = host_req.data;
				end
				state_next.upd.pulse = 1'b1;
				state_next.upd.slot = req_slot;
				state_next.upd.data = state_next.regs[req_slot];
				if (req_ofs == OFS_LOOP_BEGIN || req_ofs == OFS_LOOP_END)
				begin
					state_next.sign = state_reg.regs[SLOT_LOOP_DATA_VALUE][31];
				end
			end
		end

		// Status words come straight from the engines
		state_next.regs[SLOT_OCCLUSION_MAP_CURRENT] = engine_status.occlusion_map_current;
		state_next.regs[SLOT_COMMAND_STATE] = engine_status.command_state;
		state_next.regs[SLOT_REFRESH_CURRENT_ADDRESS] = engine_status.refresh_current_address;

		if (host_req.rd && !host_req.wr)
		begin
			state_next.rack = 1'b1;
			state_next.rdata = '0;
			if (req_hit[SLOT_W] && REG_ACC[req_slot] != RWA_WO)
			begin
				state_next.rdata = state_reg.regs[req_slot];
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_reg.regs <= {NREG{REG_RESET}};
			state_reg.sign <= 1'b0;
			state_reg.rdata <= '0;
			state_reg.rack <= 1'b0;
			state_reg.upd <= '0;
		end
		else if (clk_en)
		begin
			state_reg <= state_next;
		end
	end

	assign rd_data = state_reg.rdata;
	assign rd_ack = state_reg.rack;
	assign reg_values = state_reg.regs;
	assign reg_update = state_reg.upd;
	assign loop_sign = state_reg.sign;

endmodule

// ===== verif/rwa_properties.sv
// Port checker for the alias decoder.
// Assumes one clock, sys_clk, and synchronous reset.
`timescale 1ns/100ps
module rwa_properties
	import rwa_pkg::*;
(
	input wire logic                         sys_clk,
	input wire logic                         reset,
	input wire logic                         clk_en,
	input wire rwa_pkg::rwa_req_s            host_req,
	input wire rwa_pkg::rwa_status_s         engine_status,
	input wire logic [31:0]                  rd_data,
	input wire logic                         rd_ack,
	input wire logic [rwa_pkg::NREG-1:0][31:0] reg_values,
	input wire rwa_pkg::rwa_update_s         reg_update,
	input wire logic                         loop_sign
);
	logic       rw;
	logic       aw;
	logic [2:0] sp;
	logic [10:0] of;
	assign rw = clk_en && host_req.wr && !host_req.alt && host_req.be == 4'hf;
	assign aw = clk_en && host_req.wr && host_req.alt;
	assign sp = host_req.addr[13:11];
	assign of = {host_req.addr[10:2], 2'b00};
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_zero_replace:
		assert property (rw && sp == 3'h0 && of == OFS_LOOP_DATA_VALUE
			|=> reg_values[25] == $past(host_req.data)) else $error("replace lost");
	chk_one_accum:
		assert property (rw && sp == 3'h1 && of == OFS_LOOP_DATA_VALUE
			|=> reg_values[25] == $past(reg_values[25]) + $past(host_req.data))
			else $error("accumulate wrong");
	chk_sign_capture:
		assert property (rw && sp == 3'h0 && (of == OFS_LOOP_BEGIN || of == OFS_LOOP_END)
			|=> loop_sign == $past(reg_values[25][31])) else $error("sign not captured");
	chk_cond_replace:
		assert property (rw && sp[2] && !sp[0] && sp[1] == loop_sign && of == OFS_DITHER_ROW
			|=> reg_values[29] == $past(host_req.data)) else $error("cond replace lost");
	chk_cond_discard:
		assert property (rw && sp[2] && sp[1] != loop_sign && of == OFS_DITHER_ROW
			|=> $stable(reg_values[29])) else $error("cond write not dropped");
	chk_alt_address:
		assert property (aw && !host_req.addr[19] && !host_req.addr[2]
			|=> reg_update.pulse && reg_update.slot == SLOT_DRAW_ADDRESS)
			else $error("alt even misrouted");
	chk_alt_continue:
		assert property (aw && (host_req.addr[19] || host_req.addr[2])
			|=> reg_update.pulse && reg_update.slot == SLOT_CONTINUE_TRIGGER)
			else $error("alt continue misrouted");
	chk_partial_drop:
		assert property (clk_en && host_req.wr && !host_req.alt && host_req.be != 4'hf
			|=> !reg_update.pulse) else $error("partial write taken");

	cover property (rd_ack);
	cover property (rw && sp == 3'h7);
	cover property (aw);
endmodule

bind rwa_decoder rwa_properties u_props (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
	.host_req(host_req), .engine_status(engine_status), .rd_data(rd_data),
	.rd_ack(rd_ack), .reg_values(reg_values), .reg_update(reg_update), .loop_sign(loop_sign));

// ===== verif/rwa_host.sv
// Host bus master model issuing single register cycles.
// Assumes the decoder samples host_req at each rising sys_clk edge.
`timescale 1ns/100ps
module rwa_host
	import rwa_pkg::*;
(
	input  wire logic        sys_clk,
	output rwa_pkg::rwa_req_s req
);
	initial req = '0;
	// callers pick mapped aliases and the byte enables, partial words included
	task automatic xfer(input logic w, input logic a, input logic [19:0] ad,
		input logic [3:0] b, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{wr: w, rd: !w, alt: a, addr: ad, be: b, data: d};
		@(posedge sys_clk);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		req.addr <= ~ad;
		req.data <= ~d;
		#1;
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the alias decoder with a host model.
// Assumes a 100 MHz clock and synchronous active-high reset.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
	import rwa_pkg::*;
	logic                  sys_clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  clk_en = 1'b1;
	rwa_req_s              req;
	rwa_status_s           st = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003};
	logic [31:0]           rd_data;
	logic                  rd_ack;
	logic [NREG-1:0][31:0] rv;
	rwa_update_s           upd;
	logic                  sgn;
	logic [31:0]           q;
	int                    err_count = 0;
	int                    checked = 0;
	int                    cyc = 0;

	always #5 sys_clk = ~sys_clk;
	rwa_host host (.sys_clk(sys_clk), .req(req));
	rwa_decoder uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .host_req(req),
		.engine_status(st), .rd_data(rd_data), .rd_ack(rd_ack), .reg_values(rv),
		.reg_update(upd), .loop_sign(sgn));

	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		host.xfer(1'b1, 1'b0, a, 4'hf, d);
	endtask
	task automatic rd(input logic [19:0] a);
		host.xfer(1'b0, 1'b0, a, 4'hf, 32'h0);
		q = rd_ack ? rd_data : 32'hx;
	endtask
	task automatic t_map();
		logic [31:0] e;
		for (int i = 0; i < NREG; i++)
		begin
			e = 32'h5a00_0000 + 32'(i);
			wr({9'h0, REG_OFS[i]}, e);
			if (REG_ACC[i] != RWA_RO)
				`CHK(rv[i], e)
			else
				`CHK(upd.pulse, 1'b0)
		end
		rd(20'h001f8);
		`CHK(q, st.command_state)
		rd(20'h001f4);
		`CHK(q, st.occlusion_map_current)
	endtask
	task automatic t_freeze();
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(20'h00020, 32'h0bad_0bad);
		`CHK(rv[8], 32'h5a00_0008)
		@(posedge sys_clk);
		clk_en <= 1'b1;
		wr(20'h00020, 32'h0000_0c0c);
		`CHK(rv[8], 32'h0000_0c0c)
	endtask
	task automatic t_acc();
		wr(20'h00080, 32'h5);
		wr(20'h00880, 32'hffff_fffe);
		`CHK(rv[25], 32'h3)
		`CHK(upd.data, 32'h3)
		wr(20'h00820, 32'h1);
		`CHK(upd.pulse, 1'b0)
		host.xfer(1'b1, 1'b0, 20'h000b4, 4'h3, 32'h1);
		`CHK(upd.pulse, 1'b0)
		wr(20'hf00b7, 32'h77);
		`CHK(rv[30], 32'h77)
	endtask
	task automatic t_cond();
		logic [31:0] e;
		e = 32'h10;
		wr(20'h000b0, e);
		for (int s = 0; s < 2; s++)
		begin
			wr(20'h00080, s ? 32'h8000_0000 : 32'h0);
			wr(s ? 20'h00340 : 20'h00350, 32'h0);
			`CHK(sgn, s[0])
			for (int p = 4; p < 8; p++)
			begin
				wr({6'h0, p[2:0], 11'h0b0}, 32'h3);
				if (p[1] == s[0])
					e = p[0] ? e + 32'h3 : 32'h3;
				`CHK(rv[29], e)
			end
		end
	endtask
	task automatic alt(input logic [19:0] a, input logic [3:0] b, input logic [5:0] s);
		host.xfer(1'b1, 1'b1, a, b, {12'h0, a});
		`CHK({upd.pulse, upd.slot, rv[s]}, {1'b1, s, 12'h0, a})
	endtask
	task automatic t_mask();
		wr(20'h0002c, 32'h0f0f);
		rd(20'h0002c);
		`CHK(q, 32'h0f0f)
		wr(20'h0005c, 32'h3c3c);
		`CHK(rv[20], 32'h3c3c)
		rd(20'h0005c);
		`CHK(q, 32'h0)
	endtask
	task automatic end_of_test();
		$display("checked %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			err_count++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		t_map();
		t_freeze();
		t_acc();
		t_cond();
		alt(20'h00008, 4'h0, SLOT_DRAW_ADDRESS);
		alt(20'h7fffc, 4'h3, SLOT_CONTINUE_TRIGGER);
		alt(20'h80000, 4'hf, SLOT_CONTINUE_TRIGGER);
		t_mask();
		end_of_test();
	end
endmodule
